// ===== rtl/led_pwm_pkg.sv
`default_nettype none
package led_pwm_pkg;
  localparam int unsigned NUM_CH  = 16;
  localparam int unsigned GS_W    = 16;
  localparam int unsigned CODE_W  = 7;
  localparam int unsigned SCALE_W = 16;
  localparam int unsigned SEG_W   = 7;
  localparam int unsigned SLOT_W  = 9;
  localparam int unsigned ADDR_W  = 8;

  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] BRIGHT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] DC_BASE    = 8'h40;
  localparam logic [ADDR_W-1:0] GS_BASE    = 8'h80;

  localparam int unsigned CTRL_BLANK_BIT  = 0;
  localparam int unsigned CTRL_SPREAD_BIT = 1;
  localparam int unsigned STAT_CNT_LSB    = 0;
  localparam int unsigned STAT_BLANK_BIT  = 16;
  localparam int unsigned STAT_DONE_BIT   = 17;

  localparam logic              BLANK_RST  = 1'b1;
  localparam logic              SPREAD_RST = 1'b0;
  localparam logic [CODE_W-1:0] CODE_RST   = 7'h00;
  localparam logic [GS_W-1:0]   GS_RST     = 16'h0000;
  localparam logic [GS_W-1:0]   CNT_LAST   = 16'hFFFF;

  localparam logic [SCALE_W-1:0] BC_BASE_TERM = 16'h007F;
  localparam logic [SCALE_W-1:0] BC_STEP_MUL  = 16'h0003;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : led_pwm_pkg
`default_nettype wire

// ===== rtl/led_grayscale_pwm_brightness.sv
`default_nettype none
module led_grayscale_pwm_brightness (
  input  wire logic                                                   aclk,
  input  wire logic                                                   aresetn,
  input  wire logic [led_pwm_pkg::ADDR_W-1:0]                         s_axi_awaddr,
  input  wire logic                                                   s_axi_awvalid,
  output logic                                                        s_axi_awready,
  input  wire logic [31:0]                                            s_axi_wdata,
  input  wire logic [3:0]                                             s_axi_wstrb,
  input  wire logic                                                   s_axi_wvalid,
  output logic                                                        s_axi_wready,
  output logic [1:0]                                                  s_axi_bresp,
  output logic                                                        s_axi_bvalid,
  input  wire logic                                                   s_axi_bready,
  input  wire logic [led_pwm_pkg::ADDR_W-1:0]                         s_axi_araddr,
  input  wire logic                                                   s_axi_arvalid,
  output logic                                                        s_axi_arready,
  output logic [31:0]                                                 s_axi_rdata,
  output logic [1:0]                                                  s_axi_rresp,
  output logic                                                        s_axi_rvalid,
  input  wire logic                                                   s_axi_rready,
  input  wire logic                                                   grayscale_clock,
  output logic [led_pwm_pkg::NUM_CH-1:0]                              sink_channel,
  output logic [led_pwm_pkg::NUM_CH*led_pwm_pkg::SCALE_W-1:0]         scale_code
);
  localparam int unsigned N  = led_pwm_pkg::NUM_CH;
  localparam int unsigned GW = led_pwm_pkg::GS_W;
  localparam int unsigned CW = led_pwm_pkg::CODE_W;
  localparam int unsigned SW = led_pwm_pkg::SCALE_W;
  // bus handshake state
  logic                                  awready_q, awready_d;
  logic                                  wready_q, wready_d;
  logic                                  aw_full_q, aw_full_d;
  logic                                  w_full_q, w_full_d;
  logic [led_pwm_pkg::ADDR_W-1:0]        aw_addr_q, aw_addr_d;
  logic [31:0]                           w_data_q, w_data_d;
  logic [3:0]                            w_strb_q, w_strb_d;
  logic                                  bvalid_q, bvalid_d;
  logic [1:0]                            bresp_q, bresp_d;
  logic                                  arready_q, arready_d;
  logic                                  rvalid_q, rvalid_d;
  logic [31:0]                           rdata_q, rdata_d;
  logic [1:0]                            rresp_q, rresp_d;
  // control latches
  logic                                  blank_q, blank_d;
  logic                                  spread_q, spread_d;
  logic [CW-1:0]                         bright_q, bright_d;
  logic [CW-1:0]                         dc_q [N];
  logic [CW-1:0]                         dc_d [N];
  logic [GW-1:0]                         gs_q [N];
  logic [GW-1:0]                         gs_d [N];
  // grayscale timing
  logic                                  gck_s1_q, gck_s2_q, gck_s3_q;
  logic                                  gck_edge;
  logic [GW-1:0]                         cnt_q, cnt_d;
  logic                                  done_q, done_d;
  logic [N-1:0]                          on_q, on_d;
  logic [SW-1:0]                         scale_q [N];
  logic [SW-1:0]                         scale_d [N];
  function automatic logic [31:0] reg_word(input logic [led_pwm_pkg::ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == led_pwm_pkg::CTRL_OFS)
    begin
      v[led_pwm_pkg::CTRL_BLANK_BIT]  = blank_q;
      v[led_pwm_pkg::CTRL_SPREAD_BIT] = spread_q;
    end
    else if (a == led_pwm_pkg::BRIGHT_OFS)
      v[CW-1:0] = bright_q;
    else if (a == led_pwm_pkg::STATUS_OFS)
    begin
      v[led_pwm_pkg::STAT_CNT_LSB +: GW]  = cnt_q;
      v[led_pwm_pkg::STAT_BLANK_BIT]      = blank_q;
      v[led_pwm_pkg::STAT_DONE_BIT]       = done_q;
    end
    else if (a[7:6] == led_pwm_pkg::DC_BASE[7:6] && a[1:0] == 2'h0)
      v[CW-1:0] = dc_q[a[5:2]];
    else if (a[7:6] == led_pwm_pkg::GS_BASE[7:6] && a[1:0] == 2'h0)
      v[GW-1:0] = gs_q[a[5:2]];
    return v;
  endfunction : reg_word
  function automatic logic reg_hit(input logic [led_pwm_pkg::ADDR_W-1:0] a);
    return (a == led_pwm_pkg::CTRL_OFS) || (a == led_pwm_pkg::BRIGHT_OFS)
        || (a == led_pwm_pkg::STATUS_OFS)
        || (a[7:6] == led_pwm_pkg::DC_BASE[7:6] && a[1:0] == 2'h0)
        || (a[7:6] == led_pwm_pkg::GS_BASE[7:6] && a[1:0] == 2'h0);
  endfunction : reg_hit
  // bus slave and control latches
  always_comb
  begin
    logic [31:0] merged;
    logic        do_write;
    merged    = 32'h0000_0000;
    do_write  = aw_full_q && w_full_q && !bvalid_q;
    awready_d = awready_q;
    wready_d  = wready_q;
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    aw_addr_d = aw_addr_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    blank_d   = blank_q;
    spread_d  = spread_q;
    bright_d  = bright_q;
    dc_d      = dc_q;
    gs_d      = gs_q;

    if (s_axi_awvalid && awready_q)
    begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
      awready_d = 1'b0;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_full_d  = 1'b1;
      w_data_d  = s_axi_wdata;
      w_strb_d  = s_axi_wstrb;
      wready_d  = 1'b0;
    end
    if (do_write)
    begin
      merged = reg_word(aw_addr_q);
      for (int b = 0; b < 4; b++)
      begin
        if (w_strb_q[b])
          merged[8*b +: 8] = w_data_q[8*b +: 8];
      end
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = reg_hit(aw_addr_q) ? led_pwm_pkg::RESP_OKAY : led_pwm_pkg::RESP_SLVERR;
      if (aw_addr_q == led_pwm_pkg::CTRL_OFS)
      begin
        blank_d  = merged[led_pwm_pkg::CTRL_BLANK_BIT];
        spread_d = merged[led_pwm_pkg::CTRL_SPREAD_BIT];
      end
      else if (aw_addr_q == led_pwm_pkg::BRIGHT_OFS)
        bright_d = merged[CW-1:0];
      else if (aw_addr_q[7:6] == led_pwm_pkg::DC_BASE[7:6] && aw_addr_q[1:0] == 2'h0)
        dc_d[aw_addr_q[5:2]] = merged[CW-1:0];
      else if (aw_addr_q[7:6] == led_pwm_pkg::GS_BASE[7:6] && aw_addr_q[1:0] == 2'h0)
        gs_d[aw_addr_q[5:2]] = merged[GW-1:0];
    end
    if (bvalid_q && s_axi_bready)
    begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end

    if (s_axi_arvalid && arready_q)
    begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rdata_d   = reg_word(s_axi_araddr);
      rresp_d   = reg_hit(s_axi_araddr) ? led_pwm_pkg::RESP_OKAY : led_pwm_pkg::RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= led_pwm_pkg::RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= led_pwm_pkg::RESP_OKAY;
      blank_q   <= led_pwm_pkg::BLANK_RST;
      spread_q  <= led_pwm_pkg::SPREAD_RST;
      bright_q  <= led_pwm_pkg::CODE_RST;
      for (int i = 0; i < N; i++)
      begin
        dc_q[i] <= led_pwm_pkg::CODE_RST;
        gs_q[i] <= led_pwm_pkg::GS_RST;
      end
    end
    else
    begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      aw_addr_q <= aw_addr_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      blank_q   <= blank_d;
      spread_q  <= spread_d;
      bright_q  <= bright_d;
      dc_q      <= dc_d;
      gs_q      <= gs_d;
    end
  end

  // pin sync (two stages) plus edge flop; unreset, it tracks the idle-low pin
  always_ff @(posedge aclk)
  begin
    gck_s1_q <= grayscale_clock;
    gck_s2_q <= gck_s1_q;
    gck_s3_q <= gck_s2_q;
  end
  assign gck_edge = gck_s2_q && !gck_s3_q;
  // display period counter; freezes at zero after the 65,536th edge until reblanked
  always_comb
  begin
    cnt_d  = cnt_q;
    done_d = done_q;
    if (blank_q)
    begin
      cnt_d  = led_pwm_pkg::GS_RST;
      done_d = 1'b0;
    end
    else if (gck_edge && !done_q)
    begin
      cnt_d = cnt_q + 16'h0001;
      if (cnt_q == led_pwm_pkg::CNT_LAST)
        done_d = 1'b1;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q  <= led_pwm_pkg::GS_RST;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end
  // per-channel drive and current scaling
  for (genvar ch = 0; ch < N; ch++)
  begin : g_chan
    logic [GW-1:0]                     pos;
    logic [led_pwm_pkg::SEG_W-1:0]     seg_rev;
    logic [led_pwm_pkg::SLOT_W-1:0]    slot_len;
    logic                              conv_on;
    logic                              spread_on;

    // position 0..65535 inside the period; segment order is bit-reversed
    assign pos = cnt_q - 16'h0001;
    for (genvar b = 0; b < led_pwm_pkg::SEG_W; b++)
    begin : g_rev
      assign seg_rev[b] = pos[GW-1-b];
    end
    assign slot_len = gs_q[ch][GW-1:led_pwm_pkg::SEG_W];
    assign conv_on = (cnt_q != led_pwm_pkg::GS_RST) && (cnt_q <= gs_q[ch]);
    assign spread_on = (cnt_q != led_pwm_pkg::GS_RST)
                    && ({1'b0, pos[led_pwm_pkg::SLOT_W-1:0]}
                        < ({1'b0, slot_len}
                           + {9'h000, (seg_rev < gs_q[ch][led_pwm_pkg::SEG_W-1:0])}));

    always_comb
    begin
      if (blank_q || done_q)
        on_d[ch] = 1'b0;
      else if (spread_q)
        on_d[ch] = spread_on;
      else
        on_d[ch] = conv_on;
      // (127 + 3*bc) * dc, full scale 64516
      scale_d[ch] = (led_pwm_pkg::BC_BASE_TERM + led_pwm_pkg::BC_STEP_MUL * SW'(bright_q))
                  * SW'(dc_q[ch]);
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        on_q[ch]    <= 1'b0;
        scale_q[ch] <= 16'h0000;
      end
      else
      begin
        on_q[ch]    <= on_d[ch];
        scale_q[ch] <= scale_d[ch];
      end
    end

    assign scale_code[ch*SW +: SW] = scale_q[ch];
  end

  assign sink_channel  = on_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule : led_grayscale_pwm_brightness
`default_nettype wire

// ===== sim/gs_clock_source.sv
`default_nettype none
// far-side grayscale clock source: one pulse per request, 3 aclk high then 3 low,
// and the line stands low between pulses
module gs_clock_source (
  input  wire logic aclk,
  input  wire logic fire,
  output logic      busy,
  output logic      grayscale_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q = 3'h0;
  logic [2:0] cnt_d;
  always_comb
  begin
    cnt_d = cnt_q;
    if (cnt_q != 3'h0)
      cnt_d = cnt_q - 3'h1;
    else if (fire)
      cnt_d = 3'h6;
  end
  always_ff @(posedge aclk) cnt_q <= cnt_d;
  assign busy            = (cnt_q != 3'h0);
  assign grayscale_clock = (cnt_q > 3'h3);
endmodule : gs_clock_source
`default_nettype wire

// ===== sim/led_pwm_props.sv
`default_nettype none
module led_pwm_props (
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic [7:0]   s_axi_awaddr,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic [31:0]  s_axi_wdata,
  input wire logic [3:0]   s_axi_wstrb,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic [7:0]   s_axi_araddr,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic         grayscale_clock,
  input wire logic [15:0]  sink_channel,
  input wire logic [255:0] scale_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles since the last grayscale clock rise or write response
  logic [3:0] quiet_q, quiet_d;
  logic       gs_prev_q;
  always_comb
  begin
    quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
    if ((grayscale_clock && !gs_prev_q) || s_axi_bvalid)
      quiet_d = 4'h0;
  end
  always_ff @(posedge aclk)
  begin
    quiet_q   <= aresetn ? quiet_d : 4'h0;
    gs_prev_q <= aresetn ? grayscale_clock : 1'b0;
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_b_answer; s_wr_taken |=> ##1 s_axi_bvalid; endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  property p_aw_busy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  property p_ar_answer; s_rd_taken |=> s_axi_rvalid && !s_axi_arready; endproperty
  property p_reset;
    disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && sink_channel == '0 && scale_code == '0;
  endproperty
  property p_sink_cause; $changed(sink_channel) |-> quiet_q < 4'h8; endproperty
  property p_scale_cause; $changed(scale_code) |-> $past(s_axi_bvalid); endproperty
  a_b_answer: assert property (p_b_answer) else $error("write response late");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  a_aw_busy: assert property (p_aw_busy) else $error("second write address taken");
  a_ar_answer: assert property (p_ar_answer) else $error("read response late");
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  a_sink_cause: assert property (p_sink_cause) else $error("sink changed without cause");
  a_scale_cause: assert property (p_scale_cause) else $error("scale changed without write");
endmodule : led_pwm_props
bind led_grayscale_pwm_brightness led_pwm_props led_pwm_props_i (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .grayscale_clock,
  .sink_channel, .scale_code);
`default_nettype wire

// ===== sim/led_grayscale_pwm_brightness_tb.sv
`default_nettype none
module led_grayscale_pwm_brightness_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, busy, grayscale_clock;
  logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]   s_axi_wstrb = 4'hF;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rs;
  logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0]  sink_channel, exp_v, gs_v [16];
  logic [255:0] scale_code;
  logic [6:0]   bc, dc, dc_v [16];
  int           err_total = 0, samples_checked = 0, cycles = 0, seed = 32'h95dfac0e;
  led_grayscale_pwm_brightness led_grayscale_pwm_brightness_i (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .grayscale_clock,
    .sink_channel, .scale_code);
  gs_clock_source gs_clock_source_i (.aclk, .fire, .busy, .grayscale_clock);
  always #5 aclk = ~aclk;
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      $display("ERROR at %0t: run too long", $time);
      test_done();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 1'b1;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (b)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) rs = s_axi_bresp;
      b = !s_axi_bvalid;
      s_axi_bready <= b;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    logic r;
    r = 1'b1;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (r)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) rd = s_axi_rdata;
      if (s_axi_rvalid) rs = s_axi_rresp;
      r = !s_axi_rvalid;
      s_axi_rready <= r;
    end
  endtask : axi_rd
  // one grayscale clock pulse, then wait until the outputs have settled
  task pulse;
    @(posedge aclk);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (7) @(posedge aclk);
  endtask : pulse
  function automatic logic exp_on(logic [15:0] g, int k, logic sp);
    logic [15:0] p;
    logic [6:0]  r;
    p = 16'(k - 1);
    for (int i = 0; i < 7; i++) r[i] = p[15-i];
    if (!sp) return (k >= 1) && (k <= int'(g));
    return {1'b0, p[8:0]} < ({1'b0, g[15:7]} + 10'(r < g[6:0]));
  endfunction : exp_on
  task automatic display_run(input logic sp);
    for (int n = 0; n < 16; n++)
    begin
      gs_v[n] = (n == 0) ? 16'h0000 : (n == 15) ? 16'hFFFF : sp ? 16'($random(seed))
              : 16'({$random(seed)} % 8);
      axi_wr(led_pwm_pkg::GS_BASE + 8'(4 * n), {16'h0000, gs_v[n]});
    end
    axi_wr(led_pwm_pkg::CTRL_OFS, {30'h0, sp, 1'b0});
    for (int k = 1; k <= 6; k++)
    begin
      pulse();
      for (int n = 0; n < 16; n++) exp_v[n] = exp_on(gs_v[n], k, sp);
      chk(32'(sink_channel), 32'(exp_v));
      axi_rd(led_pwm_pkg::STATUS_OFS);
      chk(rd, 32'(k));
    end
    axi_wr(led_pwm_pkg::CTRL_OFS, {30'h0, sp, 1'b1});
    pulse();
    chk(32'(sink_channel), 32'h0);
    axi_rd(led_pwm_pkg::STATUS_OFS);
    chk(rd, 32'h0001_0000);
    $display("test display run mode %0d done", sp);
  endtask : display_run
  initial
  begin
    for (int j = 0; j < 16; j++) dc_v[j] = 7'h00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(led_pwm_pkg::CTRL_OFS);
    chk(rd, 32'h1);
    axi_rd(led_pwm_pkg::BRIGHT_OFS);
    chk(rd, 32'h0);
    chk(32'(rs), 32'(led_pwm_pkg::RESP_OKAY));
    axi_rd(8'h3C);
    chk({rd[29:0], rs}, 32'(led_pwm_pkg::RESP_SLVERR));
    axi_wr(8'h3C, 32'($random(seed)));
    chk(32'(rs), 32'(led_pwm_pkg::RESP_SLVERR));
    pulse();
    chk(32'(sink_channel), 32'h0);
    axi_rd(led_pwm_pkg::STATUS_OFS);
    chk(rd, 32'h0001_0000);
    $display("test reset and blanking done");
    for (int i = 0; i < 6; i++)
    begin
      bc = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($random(seed));
      dc = (i == 0) ? 7'h7F : (i == 1) ? 7'h01 : 7'($random(seed));
      dc_v[i * 3] = dc;
      axi_wr(led_pwm_pkg::BRIGHT_OFS, {25'h0, bc});
      axi_wr(led_pwm_pkg::DC_BASE + 8'(12 * i), {25'h0, dc});
      repeat (2) @(posedge aclk);
      for (int j = 0; j < 16; j++)
        chk(32'(scale_code[16*j+:16]), (32'd127 + 32'd3 * bc) * dc_v[j]);
      axi_rd(led_pwm_pkg::BRIGHT_OFS);
      chk(rd, {25'h0, bc});
    end
    s_axi_wstrb <= 4'hE;
    axi_wr(led_pwm_pkg::BRIGHT_OFS, 32'h0000_0000);
    s_axi_wstrb <= 4'hF;
    chk(32'(rs), 32'(led_pwm_pkg::RESP_OKAY));
    axi_rd(led_pwm_pkg::BRIGHT_OFS);
    chk(rd, {25'h0, bc});
    $display("test current scaling done");
    display_run(1'b0);
    display_run(1'b1);
    test_done();
  end
endmodule : led_grayscale_pwm_brightness_tb
`default_nettype wire
